// ---- design/cpd_pkg.sv ----
// Constants and carrier types for the character pattern display refresh block
package cpd_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [4:0] CPD_REG_CTRL = 5'h00;
    localparam logic [4:0] CPD_REG_POINTER = 5'h04;
    localparam logic [4:0] CPD_REG_CHAR_ADDR = 5'h08;
    localparam logic [4:0] CPD_REG_CHAR_DATA = 5'h0c;
    localparam logic [4:0] CPD_REG_PAT_ADDR = 5'h10;
    localparam logic [4:0] CPD_REG_PAT_DATA = 5'h14;
    localparam logic [4:0] CPD_REG_STATUS = 5'h18;

    // Control register field positions
    localparam int CPD_CTRL_DISPLAY_BIT = 0;
    localparam int CPD_CTRL_CURSOR_BIT = 1;
    localparam int CPD_CTRL_BLINK_BIT = 2;
    localparam int CPD_CTRL_FONT10_BIT = 3;
    localparam int CPD_CTRL_TWO_LINE_BIT = 4;

    // Values after reset
    localparam logic [6:0] CPD_POINTER_RESET = 7'h00;
    localparam logic [6:0] CPD_CHAR_ADDR_RESET = 7'h00;
    localparam logic [5:0] CPD_PAT_ADDR_RESET = 6'h00;

    // Panel geometry
    localparam int CPD_COMMONS = 16;
    localparam int CPD_SEGMENTS = 40;
    localparam int CPD_DOTS = 5;
    localparam int CPD_CHARS = CPD_SEGMENTS / CPD_DOTS;
    localparam logic [6:0] CPD_LINE1_BASE = 7'h40;
    localparam logic [3:0] CPD_CURSOR_ROW_8 = 4'h7;
    localparam logic [3:0] CPD_CURSOR_ROW_10 = 4'ha;
    localparam logic [3:0] CPD_LAST_COM_1L8 = 4'h7;
    localparam logic [3:0] CPD_LAST_COM_1L10 = 4'ha;
    localparam logic [3:0] CPD_LAST_COM_2L8 = 4'hf;

    // Timing counts: refresh slots per refresh step, frames per blink phase
    localparam int CPD_REFRESH_DIV = 4;
    localparam int CPD_BLINK_FRAMES = 32;

    typedef struct packed {
        logic two_line;
        logic font_5x10;
        logic blink_on;
        logic cursor_on;
        logic display_on;
    } cpd_ctrl_t;

    typedef struct packed {
        logic [7:0] code;
        logic cursor_hit;
        logic use_user;
    } cpd_char_t;

endpackage : cpd_pkg

// ---- design/cpd_refresh.sv ----
// Display refresh engine: pattern fetch, cursor overlay, serial segment drive
//
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - 5x10: code bits 2:1 give pattern address 5:4
// - 5x10: pattern address 3:0 selects the row
// - 5x10: eleventh row ORed with the cursor
// - 5x10 rows 12-16 never shown, stay storage
// - User pattern RAM only when code 7:4 zero
// - 5x10: code bits 0 and 3 ignored
// - Pattern one means lit dot
// - Refresh reads and bus accesses use separate slots
// - Sixteen common and forty segment outputs
// - Unused commons stay non-selected except for one latch after a switch to fewer commons
// - Serial shift starts at last character address
// - Latch when character 0 enters shifter
// - Cursor and blink at address pointer position
// - Pattern bit 4 is the leftmost dot
// - 5x8: code bits 2:0 give address 5:3
// - Display, cursor and blink enable bits
module cpd_refresh #(
    parameter int REFRESH_DIV = cpd_pkg::CPD_REFRESH_DIV,
    parameter int BLINK_FRAMES = cpd_pkg::CPD_BLINK_FRAMES
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [7:0] rom_code_o,
    input wire logic [3:0] rom_row_dummy_i,
    output logic [3:0] rom_row_o,
    input wire logic [4:0] rom_data_i,
    output logic [cpd_pkg::CPD_COMMONS-1:0] common_o,
    output logic [cpd_pkg::CPD_SEGMENTS-1:0] segment_o,
    output logic seg_data_o,
    output logic seg_shift_o,
    output logic seg_latch_o
);

    if (REFRESH_DIV < 1 || REFRESH_DIV > 65535)
    begin : g_bad_div
        $error("REFRESH_DIV out of range");
    end
    if (BLINK_FRAMES < 1 || BLINK_FRAMES > 65535)
    begin : g_bad_blink
        $error("BLINK_FRAMES out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic [7:0] char_ram [0:127];
    logic [7:0] pat_ram [0:63];

    cpd_pkg::cpd_ctrl_t ctrl_q;
    logic [6:0] pointer_q;
    logic [6:0] char_addr_q;
    logic [5:0] pat_addr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Slot and refresh divider
    logic slot_q;
    logic [15:0] div_q;
    logic tick_q;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            slot_q <= 1'b0;
        end
        else
        begin
            slot_q <= ~slot_q;
        end
    end

    // Divider counts only in refresh slots so the tick lands on one
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            div_q <= 16'h0000;
            tick_q <= 1'b0;
        end
        else if (!slot_q)
        begin
            if (div_q == 16'(REFRESH_DIV - 1))
            begin
                div_q <= 16'h0000;
                tick_q <= 1'b1;
            end
            else
            begin
                div_q <= div_q + 16'h0001;
                tick_q <= 1'b0;
            end
        end
        else
        begin
            tick_q <= tick_q;
        end
    end

    // Refresh step only in even slot, bus access only in odd slot
    logic refresh_en;
    assign refresh_en = tick_q && !slot_q;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave
    logic bus_req;
    logic bus_wr;
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && slot_q;
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= bus_req;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ctrl_q <= '0;
            pointer_q <= cpd_pkg::CPD_POINTER_RESET;
        end
        else if (bus_wr)
        begin
            if (wb_adr_i == cpd_pkg::CPD_REG_CTRL)
            begin
                ctrl_q <= wb_dat_i[4:0];
            end
            if (wb_adr_i == cpd_pkg::CPD_REG_POINTER)
            begin
                pointer_q <= wb_dat_i[6:0];
            end
        end
    end

    // Address registers step after each data access
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            char_addr_q <= cpd_pkg::CPD_CHAR_ADDR_RESET;
            pat_addr_q <= cpd_pkg::CPD_PAT_ADDR_RESET;
        end
        else if (bus_req)
        begin
            if (bus_wr && wb_adr_i == cpd_pkg::CPD_REG_CHAR_ADDR)
            begin
                char_addr_q <= wb_dat_i[6:0];
            end
            else if (wb_adr_i == cpd_pkg::CPD_REG_CHAR_DATA)
            begin
                char_addr_q <= char_addr_q + 7'h01;
            end
            if (bus_wr && wb_adr_i == cpd_pkg::CPD_REG_PAT_ADDR)
            begin
                pat_addr_q <= wb_dat_i[5:0];
            end
            else if (wb_adr_i == cpd_pkg::CPD_REG_PAT_DATA)
            begin
                pat_addr_q <= pat_addr_q + 6'h01;
            end
        end
    end

    // RAM writes; display-off leaves contents alone
    always_ff @(posedge clk_i)
    begin
        if (bus_wr && wb_adr_i == cpd_pkg::CPD_REG_CHAR_DATA)
        begin
            char_ram[char_addr_q] <= wb_dat_i[7:0];
        end
        if (bus_wr && wb_adr_i == cpd_pkg::CPD_REG_PAT_DATA)
        begin
            pat_ram[pat_addr_q] <= wb_dat_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Refresh sequencer
    typedef enum logic [3:0] {
        CPD_ST_CHAR = 4'b0001,
        CPD_ST_PAT = 4'b0010,
        CPD_ST_SHIFT = 4'b0100,
        CPD_ST_LATCH = 4'b1000
    } cpd_state_t;

    cpd_state_t state_q;
    logic [2:0] ch_q;
    logic [2:0] col_q;
    logic [3:0] com_q;
    logic [15:0] frame_q;
    logic blink_phase_q;
    cpd_pkg::cpd_char_t cur_q;
    logic [4:0] user_row_q;
    logic [cpd_pkg::CPD_SEGMENTS-1:0] shreg_q;

    logic [3:0] row;
    logic line1;
    logic [6:0] char_idx;
    logic [5:0] user_idx;
    logic [3:0] last_com;
    logic cursor_row;
    logic [4:0] dots;
    logic [4:0] shown;

    always_comb
    begin
        line1 = ctrl_q.two_line && com_q[3];
        row = ctrl_q.two_line ? {1'b0, com_q[2:0]} : com_q;
        char_idx = (line1 ? cpd_pkg::CPD_LINE1_BASE : 7'h00) + {4'h0, ch_q};
        if (ctrl_q.font_5x10 && !ctrl_q.two_line)
        begin
            user_idx = {cur_q.code[2:1], row};
            cursor_row = (row == cpd_pkg::CPD_CURSOR_ROW_10);
        end
        else
        begin
            user_idx = {cur_q.code[2:0], row[2:0]};
            cursor_row = (row[2:0] == cpd_pkg::CPD_CURSOR_ROW_8[2:0]);
        end
        // Two-line mode always uses 5x8 rows
        if (ctrl_q.two_line)
        begin
            last_com = cpd_pkg::CPD_LAST_COM_2L8;
        end
        else if (ctrl_q.font_5x10)
        begin
            last_com = cpd_pkg::CPD_LAST_COM_1L10;
        end
        else
        begin
            last_com = cpd_pkg::CPD_LAST_COM_1L8;
        end
    end

    // Dot data for the current row, one means lit
    always_comb
    begin
        dots = cur_q.use_user ? user_row_q : rom_data_i;
        shown = dots;
        if (cursor_row && ctrl_q.cursor_on && cur_q.cursor_hit)
        begin
            shown = dots | 5'h1f;
        end
        if (ctrl_q.blink_on && cur_q.cursor_hit && blink_phase_q)
        begin
            shown = 5'h1f;
        end
        if (!ctrl_q.display_on)
        begin
            shown = 5'h00;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_q <= CPD_ST_CHAR;
            ch_q <= 3'(cpd_pkg::CPD_CHARS - 1);
            col_q <= 3'h0;
        end
        else if (refresh_en)
        begin
            unique case (state_q)
                CPD_ST_CHAR:
                begin
                    state_q <= CPD_ST_PAT;
                end
                CPD_ST_PAT:
                begin
                    state_q <= CPD_ST_SHIFT;
                    col_q <= 3'h0;
                end
                CPD_ST_SHIFT:
                begin
                    if (col_q == 3'(cpd_pkg::CPD_DOTS - 1))
                    begin
                        col_q <= 3'h0;
                        if (ch_q == 3'h0)
                        begin
                            state_q <= CPD_ST_LATCH;
                        end
                        else
                        begin
                            ch_q <= ch_q - 3'h1;
                            state_q <= CPD_ST_CHAR;
                        end
                    end
                    else
                    begin
                        col_q <= col_q + 3'h1;
                    end
                end
                CPD_ST_LATCH:
                begin
                    ch_q <= 3'(cpd_pkg::CPD_CHARS - 1);
                    state_q <= CPD_ST_CHAR;
                end
            endcase
        end
    end

    // Character fetch and pattern fetch
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cur_q <= '0;
            user_row_q <= 5'h00;
            rom_code_o <= 8'h00;
            rom_row_o <= 4'h0;
        end
        else if (refresh_en && state_q == CPD_ST_CHAR)
        begin
            cur_q.code <= char_ram[char_idx];
            cur_q.cursor_hit <= (char_idx == pointer_q);
            cur_q.use_user <= (char_ram[char_idx][7:4] == 4'h0);
        end
        else if (refresh_en && state_q == CPD_ST_PAT)
        begin
            user_row_q <= pat_ram[user_idx][4:0];
            rom_code_o <= cur_q.code;
            rom_row_o <= row;
        end
    end

    // Serial shift, bit 0 first so bit 4 lands leftmost
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            shreg_q <= '0;
            seg_data_o <= 1'b0;
            seg_shift_o <= 1'b0;
        end
        else if (refresh_en && state_q == CPD_ST_SHIFT)
        begin
            shreg_q <= {shreg_q[cpd_pkg::CPD_SEGMENTS-2:0], shown[col_q]};
            seg_data_o <= shown[col_q];
            seg_shift_o <= 1'b1;
        end
        else
        begin
            seg_shift_o <= 1'b0;
        end
    end

    // Latch once character 0 has entered the shifter
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            segment_o <= '0;
            common_o <= '0;
            seg_latch_o <= 1'b0;
            com_q <= 4'h0;
            frame_q <= 16'h0000;
            blink_phase_q <= 1'b0;
        end
        else if (refresh_en && state_q == CPD_ST_LATCH)
        begin
            segment_o <= shreg_q;
            common_o <= 16'h0001 << com_q;
            seg_latch_o <= 1'b1;
            if (com_q >= last_com)
            begin
                com_q <= 4'h0;
                if (frame_q == 16'(BLINK_FRAMES - 1))
                begin
                    frame_q <= 16'h0000;
                    blink_phase_q <= ~blink_phase_q;
                end
                else
                begin
                    frame_q <= frame_q + 16'h0001;
                end
            end
            else
            begin
                com_q <= com_q + 4'h1;
            end
        end
        else
        begin
            seg_latch_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, registered with the acknowledge
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (bus_req)
        begin
            unique case (wb_adr_i)
                cpd_pkg::CPD_REG_CTRL: wb_dat_o <= {27'h0, ctrl_q};
                cpd_pkg::CPD_REG_POINTER: wb_dat_o <= {25'h0, pointer_q};
                cpd_pkg::CPD_REG_CHAR_ADDR: wb_dat_o <= {25'h0, char_addr_q};
                cpd_pkg::CPD_REG_CHAR_DATA: wb_dat_o <= {24'h0, char_ram[char_addr_q]};
                cpd_pkg::CPD_REG_PAT_ADDR: wb_dat_o <= {26'h0, pat_addr_q};
                cpd_pkg::CPD_REG_PAT_DATA: wb_dat_o <= {24'h0, pat_ram[pat_addr_q]};
                cpd_pkg::CPD_REG_STATUS:
                    wb_dat_o <= {11'h0, blink_phase_q, com_q, frame_q};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

endmodule : cpd_refresh

// ---- verif/cpd_refresh_chk.sv ----
// Assertion checker for the display refresh block
`timescale 1ns/1ns
module cpd_refresh_chk #(
    parameter int REFRESH_DIV = 4,
    parameter int BLINK_FRAMES = 32
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] rom_code_o,
    input wire logic [3:0] rom_row_dummy_i,
    input wire logic [3:0] rom_row_o,
    input wire logic [4:0] rom_data_i,
    input wire logic [15:0] common_o,
    input wire logic [39:0] segment_o,
    input wire logic seg_data_o,
    input wire logic seg_shift_o,
    input wire logic seg_latch_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    logic [5:0] shift_cnt_q;
    logic [39:0] shreg_q;
    ////////////////////////////////////////
    // Rebuild the latched row from the serial stream
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            shift_cnt_q <= 6'h00;
            shreg_q <= 40'h0;
        end
        else if (seg_latch_o)
        begin
            shift_cnt_q <= 6'h00;
        end
        else if (seg_shift_o)
        begin
            shift_cnt_q <= shift_cnt_q + 6'h01;
            shreg_q <= {shreg_q[38:0], seg_data_o};
        end
    end
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_bound_a: assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##[1:2] wb_ack_o)
        else $error("bus request not answered in time");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 5'h18
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    com_onehot_a: assert property (seg_latch_o |-> $onehot(common_o))
        else $error("latched commons not one-hot");
    com_stable_a: assert property (!seg_latch_o |-> $stable(common_o))
        else $error("commons changed without latch");
    seg_stable_a: assert property (!seg_latch_o |-> $stable(segment_o))
        else $error("segments changed without latch");
    shift_count_a: assert property (seg_latch_o |-> shift_cnt_q == 6'h28)
        else $error("latch after wrong number of shifts");
    seg_order_a: assert property (seg_latch_o |-> segment_o == shreg_q)
        else $error("latched segments differ from serial stream");
    latch_excl_a: assert property (seg_latch_o |-> !seg_shift_o)
        else $error("latch and shift together");
endmodule : cpd_refresh_chk

bind cpd_refresh cpd_refresh_chk #(.REFRESH_DIV(REFRESH_DIV), .BLINK_FRAMES(BLINK_FRAMES))
    i_cpd_refresh_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rom_code_o(rom_code_o),
    .rom_row_dummy_i(rom_row_dummy_i), .rom_row_o(rom_row_o), .rom_data_i(rom_data_i),
    .common_o(common_o), .segment_o(segment_o), .seg_data_o(seg_data_o),
    .seg_shift_o(seg_shift_o), .seg_latch_o(seg_latch_o));

// ---- verif/cpd_refresh_tb_top.sv ----
// Self-checking bench for the display refresh block
`timescale 1ns/1ns
module cpd_refresh_tb_top;
    typedef struct packed {
        logic [4:0] ctrl;
        logic [6:0] ptr;
        logic [3:0] com;
        logic [3:0] last;
    } cpd_tb_case_t;
    localparam logic [63:0] CODES = 64'h08874110_0f0a0900;
    logic clk_i = 1'b0, reset_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [4:0] wb_adr_i = 5'h00, rom_data_i;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdata;
    logic wb_ack_o, seg_data_o, seg_shift_o, seg_latch_o;
    logic [7:0] rom_code_o, char_ram [0:127];
    logic [3:0] rom_row_o;
    logic [15:0] common_o;
    logic [39:0] segment_o;
    logic [4:0] pat_ram [0:63];
    int error_cnt = 0, n_tests = 0, lit_n = 0, plain_n = 0;
    cpd_tb_case_t c;
    cpd_tb_case_t cases [10] = '{'{5'h01, 7'h00, 4'h3, 4'h7}, '{5'h03, 7'h02, 4'h7, 4'h7},
        '{5'h09, 7'h00, 4'h2, 4'ha}, '{5'h0b, 7'h05, 4'ha, 4'ha}, '{5'h11, 7'h00, 4'h9, 4'hf},
        '{5'h13, 7'h43, 4'hf, 4'hf}, '{5'h00, 7'h00, 4'h4, 4'h7}, '{5'h0a, 7'h01, 4'ha, 4'ha},
        '{5'h0b, 7'h01, 4'ha, 4'ha}, '{5'h1b, 7'h47, 4'hf, 4'hf}};

    cpd_refresh #(.REFRESH_DIV(1), .BLINK_FRAMES(2)) i_cpd_refresh (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rom_code_o(rom_code_o), .rom_row_dummy_i(4'h0),
        .rom_row_o(rom_row_o), .rom_data_i(rom_data_i), .common_o(common_o),
        .segment_o(segment_o), .seg_data_o(seg_data_o), .seg_shift_o(seg_shift_o),
        .seg_latch_o(seg_latch_o));
    cpd_rom_model i_cpd_rom_model (.rom_code_i(rom_code_o), .rom_row_i(rom_row_o),
        .rom_data_o(rom_data_i));

    always #4 clk_i = ~clk_i;
    ////////////////////////////////////////
    task automatic report_and_stop();
        $display("Counts: %0d checks, %0d mismatches", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] wd);
        int k;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, adr, wd, 4'hf};
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (wb_ack_o !== 1'b1)
        begin
            error_cnt++;
            report_and_stop();
        end
        rdata = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb

    task automatic wait_row(input logic [3:0] com, input logic [3:0] last);
        logic [15:0] used;
        used = 16'((32'h1 << (last + 1)) - 1);
        for (int k = 0; k < 6000; k++)
        begin
            @(negedge clk_i);
            if (seg_latch_o === 1'b1)
            begin
                check(40'(common_o & ~used), 40'h0, "unused common");
                if (common_o[com] === 1'b1)
                    return;
            end
        end
        error_cnt++;
        report_and_stop();
    endtask : wait_row

    function automatic logic [39:0] exp_row(input cpd_tb_case_t r);
        logic [39:0] s;
        logic [6:0] a;
        logic [7:0] code;
        logic [3:0] row;
        logic [4:0] d;
        logic f10;
        s = 40'h0;
        f10 = r.ctrl[3] && !r.ctrl[4];
        row = r.ctrl[4] ? {1'b0, r.com[2:0]} : r.com;
        for (int ch = 0; ch < 8; ch++)
        begin
            a = (r.ctrl[4] && r.com >= 4'h8) ? 7'(64 + ch) : 7'(ch);
            code = char_ram[a];
            if (code[7:4] == 4'h0)
                d = f10 ? pat_ram[{code[2:1], row}] : pat_ram[{code[2:0], row[2:0]}];
            else
                d = code[4:0] ^ {1'b0, row};
            if (r.ctrl[1] && row == (f10 ? 4'ha : 4'h7) && a == r.ptr)
                d = 5'h1f;
            if (!r.ctrl[0])
                d = 5'h00;
            for (int col = 0; col < 5; col++)
                s[ch * 5 + col] = d[4 - col];
        end
        return s;
    endfunction : exp_row

    task automatic setup(input cpd_tb_case_t r);
        wb(1'b1, cpd_pkg::CPD_REG_CTRL, 32'(r.ctrl));
        wb(1'b1, cpd_pkg::CPD_REG_POINTER, 32'(r.ptr));
        // Let the old scan wrap to common 0 before unused commons are judged
        wait_row(4'h0, 4'hf);
    endtask : setup
    ////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 64; i++)
            pat_ram[i] = (i[3:0] == 4'ha) ? 5'h00 : 5'(i * 7 + 3);
        repeat (16) @(posedge clk_i);
        check(segment_o ^ 40'(common_o), 40'h0, "outputs in reset");
        reset_n_i <= 1'b1;
        wb(1'b0, cpd_pkg::CPD_REG_CTRL, 32'h0);
        check(40'(rdata), 40'h0, "control after reset");
        wb(1'b0, 5'h1c, 32'h0);
        check(40'(rdata), 40'h0, "unmapped read");
        wb(1'b1, cpd_pkg::CPD_REG_CHAR_ADDR, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            char_ram[i] = CODES[i * 8 +: 8];
            wb(1'b1, cpd_pkg::CPD_REG_CHAR_DATA, 32'(char_ram[i]));
        end
        wb(1'b1, cpd_pkg::CPD_REG_CHAR_ADDR, 32'h40);
        for (int i = 64; i < 72; i++)
        begin
            char_ram[i] = 8'(8'h20 + i);
            wb(1'b1, cpd_pkg::CPD_REG_CHAR_DATA, 32'(char_ram[i]));
        end
        wb(1'b1, cpd_pkg::CPD_REG_PAT_ADDR, 32'h0);
        for (int i = 0; i < 64; i++)
            wb(1'b1, cpd_pkg::CPD_REG_PAT_DATA, 32'(pat_ram[i]));
        $display("Test reset and load done");
        foreach (cases[i])
        begin
            setup(cases[i]);
            wait_row(cases[i].com, cases[i].last);
            check(segment_o, exp_row(cases[i]), "row");
        end
        $display("Test table done");
        wb(1'b1, cpd_pkg::CPD_REG_PAT_ADDR, 32'h0b);
        for (int i = 11; i < 16; i++)
        begin
            wb(1'b0, cpd_pkg::CPD_REG_PAT_DATA, 32'h0);
            check(40'(rdata[4:0]), 40'(pat_ram[i]), "spare rows");
        end
        c = cases[0];
        setup(c);
        fork
            repeat (10)
            begin
                wb(1'b1, cpd_pkg::CPD_REG_CHAR_ADDR, 32'h2);
                wb(1'b1, cpd_pkg::CPD_REG_CHAR_DATA, 32'(char_ram[2]));
            end
            repeat (3)
            begin
                wait_row(c.com, c.last);
                check(segment_o, exp_row(c), "row during writes");
            end
        join
        $display("Test writes during refresh done");
        c = '{5'h05, 7'h04, 4'h0, 4'h7};
        setup(c);
        repeat (8)
        begin
            wait_row(c.com, c.last);
            if (segment_o[24:20] === 5'h1f)
                lit_n++;
            else
                plain_n++;
            if (segment_o[24:20] !== 5'h1f)
                check(segment_o, exp_row(c), "blink off phase");
        end
        check(40'(lit_n > 0 && plain_n > 0), 40'h1, "blink phases");
        $display("Test blink done");
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check(segment_o ^ 40'(common_o), 40'h0, "outputs in second reset");
        reset_n_i <= 1'b1;
        wb(1'b0, cpd_pkg::CPD_REG_CTRL, 32'h0);
        check(40'(rdata), 40'h0, "control after second reset");
        $display("Test second reset done");
        report_and_stop();
    end
endmodule : cpd_refresh_tb_top

// ---- verif/cpd_rom_model.sv ----
// Fixed pattern ROM model answering the refresh engine's row fetches
`timescale 1ns/1ns
module cpd_rom_model (
    input wire logic [7:0] rom_code_i,
    input wire logic [3:0] rom_row_i,
    output logic [4:0] rom_data_o
);
    // Row dots differ per code and row; bit 4 is the leftmost dot
    assign rom_data_o = rom_code_i[4:0] ^ {1'b0, rom_row_i};
endmodule : cpd_rom_model
